//--- core/blfs_pkg.sv
// Shared constants and types of the boost LED fault sequencer.
package blfs_pkg;

	// Clock and timing figures.
	localparam int unsigned CLK_MHZ        = 100;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	localparam int unsigned STBY_TIME_MS   = 20;
	localparam int unsigned COMP_TIME_MS   = 37;
	localparam int unsigned MIN_ON_NS      = 600;
	localparam int unsigned SW_FREQ_KHZ    = 120;
	localparam int unsigned MAX_DUTY_PCT   = 95;
	localparam int unsigned CS_HIGH_CYCLES = 17;

	// Derived cycle counts.
	localparam int unsigned STBY_CYC_DEF = STBY_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned COMP_CYC_DEF = COMP_TIME_MS * 1000 * CLK_MHZ;
	localparam int unsigned MIN_ON_CYC   = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SW_PERIOD    = (CLK_MHZ * 1000) / SW_FREQ_KHZ;
	localparam int unsigned MAX_ON_CYC   = (SW_PERIOD * MAX_DUTY_PCT) / 100;

	localparam logic [9:0] SW_LAST      = 10'(SW_PERIOD - 1);
	localparam logic [9:0] MIN_ON_LAST  = 10'(MIN_ON_CYC - 1);
	localparam logic [9:0] MAX_ON_LAST  = 10'(MAX_ON_CYC - 1);
	localparam logic [4:0] CS_TRIP_CNT  = 5'(CS_HIGH_CYCLES);

	// Register offsets.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_MASK   = 8'h04;
	localparam logic [7:0] OFS_CTRL   = 8'h08;
	localparam logic [7:0] OFS_STATE  = 8'h0C;

	// Control field position and reset value.
	localparam int unsigned CTRL_INHIBIT_BIT = 0;
	localparam logic        CTRL_INHIBIT_RST = 1'h0;

	// Event bit positions in status and mask.
	localparam int unsigned EV_WAKE  = 0;
	localparam int unsigned EV_STBY  = 1;
	localparam int unsigned EV_OVP   = 2;
	localparam int unsigned EV_OTP   = 3;
	localparam int unsigned EV_SHORT = 4;
	localparam int unsigned EV_COMP  = 5;
	localparam int unsigned EV_CS    = 6;
	localparam int unsigned EV_TOPO  = 7;
	localparam int unsigned EV_W     = 8;

	// Comparator input bit positions.
	localparam int unsigned IN_DIM       = 0;
	localparam int unsigned IN_SUPPLY_OK = 1;
	localparam int unsigned IN_OVS_START = 2;
	localparam int unsigned IN_OVS_SHORT = 3;
	localparam int unsigned IN_OVS_OVER  = 4;
	localparam int unsigned IN_CS_HIGH   = 5;
	localparam int unsigned IN_COMP_HIGH = 6;
	localparam int unsigned IN_FB_HIGH   = 7;
	localparam int unsigned IN_OCP       = 8;
	localparam int unsigned IN_OTP       = 9;
	localparam int unsigned IN_PEAK      = 10;
	localparam int unsigned IN_PULSE_REQ = 11;
	localparam int unsigned IN_W         = 12;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_CHECK,
		ST_RUN,
		ST_OVP_WAIT,
		ST_OTP_WAIT,
		ST_LATCHED
	} blfs_mode_e;

	typedef struct packed {
		blfs_mode_e         state;
		logic [IN_W-1:0]    sync1;
		logic [IN_W-1:0]    sync2;
		logic               dim_prev;
		logic [9:0]         sw_cnt;
		logic               cs_seen;
		logic [4:0]         cs_cnt;
		logic [21:0]        comp_cnt;
		logic [21:0]        stby_cnt;
		logic [EV_W-1:0]    status;
		logic [EV_W-1:0]    mask;
		logic               inhibit;
		logic [31:0]        rd_data;
		logic               irq;
		logic               gate;
		logic               comp_dis;
		logic               ss_rel;
		logic               standby;
		logic               dim_ref;
	} blfs_state_s;

endpackage : blfs_pkg

//--- core/blfs_top.sv
// Boost LED fault sequencer: wake/standby, start-up check, gate control and fault latches.
//
// How it works
// - A rising dimming edge in standby wakes the device at once.
// - Dimming low continuously for the standby time puts the device in standby.
// - At start-up a low output sense level keeps the gate disabled.
// - Soft-start is released only with no fault flags present.
// - Nothing runs while the supply-good flag is low.
// - Gate on-time ends when the peak current comparator trips.
// - Pulses are skipped at light load; a pulse ends before 600 ns only on inhibit or on leaving the run state.
// - An internal square wave follows the dimming duty cycle.
// - Overvoltage stops switching and discharges the compensation node.
// - After overvoltage clears, a fresh start-up and soft-start follow.
// - Compensation high for 37 ms continuously latches the gate off.
// - Current-sense high in 17 consecutive switching cycles latches the gate off.
// - Output short during running turns the gate off.
// - The short latch clears only through supply or dimming cycling.
// - Overtemperature shuts down; restart follows when the flag clears.
`timescale 1ns/1ns
module blfs_top import blfs_pkg::*; #(
	parameter int unsigned STBY_CYC = STBY_CYC_DEF,
	parameter int unsigned COMP_CYC = COMP_CYC_DEF
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Comparator flags from the analog front end.
	input  wire logic        dim_in,
	input  wire logic        supply_ok,
	input  wire logic        ovs_start_low,
	input  wire logic        ovs_short,
	input  wire logic        ovs_over,
	input  wire logic        cs_high,
	input  wire logic        comp_high,
	input  wire logic        fb_high,
	input  wire logic        ocp_trip,
	input  wire logic        otp_hot,
	input  wire logic        peak_trip,
	input  wire logic        pulse_req,
	// Register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Power stage controls.
	output logic             gate_out,
	output logic             comp_discharge,
	output logic             soft_start_en,
	output logic             standby_out,
	output logic             dim_ref_out,
	output logic             irq
);

	blfs_state_s     q;
	blfs_state_s     n;
	logic [IN_W-1:0] raw;
	logic [IN_W-1:0] s;
	logic [EV_W-1:0] ev;
	logic            period_end;
	logic            fault;
	logic            cs_trip;
	logic            comp_trip;
	logic            stby_go;

	assign raw = {pulse_req, peak_trip, otp_hot, ocp_trip, fb_high, comp_high,
		cs_high, ovs_over, ovs_short, ovs_start_low, supply_ok, dim_in};
	assign s   = q.sync2;

	always_comb begin
		n          = q;
		ev         = '0;
		n.sync1    = raw;
		n.sync2    = q.sync1;
		n.dim_prev = s[IN_DIM];
		n.rd_data  = '0;
		period_end = (q.sw_cnt == SW_LAST);
		n.sw_cnt   = period_end ? 10'h000 : q.sw_cnt + 10'h001;
		fault      = s[IN_CS_HIGH] | s[IN_COMP_HIGH] | s[IN_FB_HIGH] | s[IN_OCP] | s[IN_OTP] | ~s[IN_SUPPLY_OK];
		cs_trip    = 1'b0;
		comp_trip  = 1'b0;
		stby_go    = 1'b0;

		// Standby qualification runs while powered, counted on this clock.
		if (q.state != ST_STANDBY && !s[IN_DIM]) begin
			if (q.stby_cnt == 22'(STBY_CYC - 1)) begin
				stby_go = 1'b1;
			end
			n.stby_cnt = q.stby_cnt + 22'h00_0001;
		end else begin
			n.stby_cnt = '0;
		end

		// Fault counters only count while switching.
		if (q.state == ST_RUN) begin
			n.cs_seen = q.cs_seen | s[IN_CS_HIGH];
			if (period_end) begin
				n.cs_cnt  = n.cs_seen ? q.cs_cnt + 5'h01 : 5'h00;
				n.cs_seen = 1'b0;
			end
			cs_trip = (q.cs_cnt == CS_TRIP_CNT);
			if (s[IN_COMP_HIGH]) begin
				comp_trip  = (q.comp_cnt == 22'(COMP_CYC - 1));
				n.comp_cnt = q.comp_cnt + 22'h00_0001;
			end else begin
				n.comp_cnt = '0;
			end
		end else begin
			n.cs_seen  = 1'b0;
			n.cs_cnt   = '0;
			n.comp_cnt = '0;
		end

		case (q.state)
			ST_STANDBY: begin
				if (s[IN_DIM] && !q.dim_prev) begin
					n.state     = ST_CHECK;
					ev[EV_WAKE] = 1'b1;
				end
			end
			ST_CHECK: begin
				if (s[IN_OVS_START]) begin
					ev[EV_TOPO] = 1'b1;
				end else if (!fault) begin
					n.state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (s[IN_OVS_OVER]) begin
					n.state    = ST_OVP_WAIT;
					ev[EV_OVP] = 1'b1;
				end else if (s[IN_OTP]) begin
					n.state    = ST_OTP_WAIT;
					ev[EV_OTP] = 1'b1;
				end else if (s[IN_OVS_SHORT]) begin
					n.state      = ST_LATCHED;
					ev[EV_SHORT] = 1'b1;
				end else if (comp_trip) begin
					n.state     = ST_LATCHED;
					ev[EV_COMP] = 1'b1;
				end else if (cs_trip) begin
					n.state   = ST_LATCHED;
					ev[EV_CS] = 1'b1;
				end
			end
			ST_OVP_WAIT: begin
				// The comparator carries the 100 mV hysteresis, so its release is the restart point.
				if (!s[IN_OVS_OVER]) begin
					n.state = ST_CHECK;
				end
			end
			ST_OTP_WAIT: begin
				if (!s[IN_OTP]) begin
					n.state = ST_CHECK;
				end
			end
			ST_LATCHED: begin
				n.state = ST_LATCHED;
			end
			default: begin
				n.state = ST_STANDBY;
			end
		endcase

		if (stby_go) begin
			n.state     = ST_STANDBY;
			ev[EV_STBY] = 1'b1;
		end

		// Gate: a pulse opens at the period start only when the loop asks for one.
		if (q.state == ST_RUN && n.state == ST_RUN && !q.inhibit) begin
			if (period_end) begin
				n.gate = s[IN_PULSE_REQ];
			end else if (q.gate && q.sw_cnt >= MIN_ON_LAST && (s[IN_PEAK] || q.sw_cnt >= MAX_ON_LAST)) begin
				n.gate = 1'b0;
			end
		end else begin
			n.gate = 1'b0;
		end

		// Register port; a set in the same cycle as a clear wins.
		if (reg_wr) begin
			case (reg_addr)
				OFS_STATUS: n.status = q.status & ~reg_wdata[EV_W-1:0];
				OFS_MASK:   n.mask = reg_wdata[EV_W-1:0];
				OFS_CTRL:   n.inhibit = reg_wdata[CTRL_INHIBIT_BIT];
				default:    n.mask = q.mask;
			endcase
		end
		n.status = n.status | ev;
		if (reg_rd) begin
			case (reg_addr)
				OFS_STATUS: n.rd_data = {24'h00_0000, q.status};
				OFS_MASK:   n.rd_data = {24'h00_0000, q.mask};
				OFS_CTRL:   n.rd_data = {31'h0000_0000, q.inhibit};
				OFS_STATE:  n.rd_data = {28'h000_0000, q.gate, q.state};
				default:    n.rd_data = '0;
			endcase
		end

		n.irq      = |(n.status & n.mask);
		n.comp_dis = (n.state == ST_OVP_WAIT);
		n.ss_rel   = (n.state == ST_RUN);
		n.standby  = (n.state == ST_STANDBY);
		n.dim_ref  = s[IN_DIM];

		// Undervoltage returns everything to power-down; only the synchronisers keep running.
		if (!s[IN_SUPPLY_OK]) begin
			n         = '0;
			n.inhibit = CTRL_INHIBIT_RST;
			n.standby = 1'b1;
			n.sync1   = raw;
			n.sync2   = q.sync1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign reg_rdata      = q.rd_data;
	assign gate_out       = q.gate;
	assign comp_discharge = q.comp_dis;
	assign soft_start_en  = q.ss_rel;
	assign standby_out    = q.standby;
	assign dim_ref_out    = q.dim_ref;
	assign irq            = q.irq;

endmodule : blfs_top

//--- verif/blfs_chk.sv
// Port-level assertions of the boost LED fault sequencer.
`timescale 1ns/1ns
module blfs_chk import blfs_pkg::*; #(
	parameter int unsigned STBY_CYC = STBY_CYC_DEF
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Watched flags.
	input wire logic dim_in,
	input wire logic supply_ok,
	input wire logic ovs_short,
	input wire logic ovs_over,
	input wire logic otp_hot,
	// Watched outputs.
	input wire logic gate_out,
	input wire logic comp_discharge,
	input wire logic soft_start_en,
	input wire logic standby_out,
	input wire logic dim_ref_out,
	input wire logic irq
);
	logic [9:0]  on_q;
	logic [21:0] low_q;
	logic        ran_q;
	// The low counter saturates so that a long standby cannot wrap it.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_q  <= 10'h000;
			low_q <= 22'h00_0000;
			ran_q <= 1'h0;
		end else begin
			on_q  <= gate_out ? on_q + 10'h001 : 10'h000;
			low_q <= dim_in ? 22'h00_0000 : low_q + 22'(low_q != 22'h3F_FFFF);
			ran_q <= supply_ok && (ran_q || soft_start_en);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_min_on: assert property ($fell(gate_out) && soft_start_en |-> on_q >= MIN_ON_CYC)
		else $error("gate pulse shorter than the minimum on-time");
	a_max_on: assert property (on_q <= MAX_ON_CYC)
		else $error("gate on-time beyond the maximum");
	a_gate_idle: assert property (!soft_start_en && !$past(soft_start_en) |-> !gate_out)
		else $error("gate driven outside soft-start");
	a_ovp_stop: assert property (ovs_over && soft_start_en |-> ##[1:5] (comp_discharge && !gate_out))
		else $error("overvoltage did not stop switching");
	a_short_stop: assert property (ovs_short && soft_start_en |-> ##[1:5] !soft_start_en)
		else $error("output short did not stop switching");
	a_otp_stop: assert property (otp_hot && soft_start_en |-> ##[1:5] !soft_start_en)
		else $error("overtemperature did not shut down");
	a_uvlo_off: assert property (!supply_ok [*5] |-> standby_out && !soft_start_en && !gate_out && !irq)
		else $error("outputs active during undervoltage");
	a_dim_follow: assert property (supply_ok && $past(supply_ok, 4) |-> dim_ref_out == $past(dim_in, 3))
		else $error("dimming reference does not follow the input");
	a_wake_fast: assert property ($rose(dim_in) && standby_out && supply_ok && $past(supply_ok, 4)
		|-> ##[1:6] !standby_out)
		else $error("no wake-up after dimming edge");
	a_stby_wait: assert property ($rose(standby_out) && ran_q |-> low_q >= STBY_CYC)
		else $error("standby entered too early");
endmodule : blfs_chk

//--- verif/blfs_partner.sv
// Dimming source and power stage stand-in.
`timescale 1ns/1ns
module blfs_partner (
	// Clock and controls.
	input  wire logic       clk,
	input  wire logic       dim_on,
	input  wire logic [9:0] peak_at,
	// Power stage side.
	input  wire logic       gate_out,
	output logic            dim_in,
	output logic            peak_trip
);
	logic [12:0] ph_q = 13'h0000;
	logic [9:0]  on_q = 10'h000;
	// A 20 kHz half-duty wave; its low phase stays shorter than the standby time.
	always @(posedge clk) begin
		ph_q <= (ph_q == 13'h1387) ? 13'h0000 : ph_q + 13'h0001;
		on_q <= gate_out ? on_q + 10'h001 : 10'h000;
	end
	assign dim_in    = dim_on && (ph_q < 13'h09C4);
	assign peak_trip = gate_out && (on_q >= peak_at);
endmodule : blfs_partner

//--- verif/blfs_top_tb.sv
// Testbench of the boost LED fault sequencer.
`timescale 1ns/1ns
module blfs_top_tb import blfs_pkg::*; ;
	localparam int unsigned STBY = 5000;
	logic clk = 1'h0, rst_n = 1'h0, supply_ok = 1'h1, dim_on = 1'h0, pulse_req = 1'h0;
	logic ovs_start_low = 1'h0, ovs_short = 1'h0, ovs_over = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic cs_high = 1'h0, comp_high = 1'h0, fb_high = 1'h0, ocp_trip = 1'h0, otp_hot = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
	logic [9:0]  peak_at = 10'h00A;
	logic dim_in, peak_trip, gate_out, comp_discharge, soft_start_en, standby_out, dim_ref_out, irq;
	int failures = 0, comparisons = 0, n, i, lo;
	blfs_partner PM (.*);
	blfs_top #(.STBY_CYC(STBY), .COMP_CYC(40)) DUT (.*);
	always #5 clk = ~clk;
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask : rd
	task automatic complete_run;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		#1_000_000;
		failures++;
		complete_run;
	end
	initial begin
		cyc(12);
		rst_n <= 1'h1;
		cyc(2);
		chk("standby", standby_out, 1'h1);
		rd(OFS_MASK, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		wr(OFS_MASK, 32'h0000_0001);
		ovs_start_low <= 1'h1;
		dim_on <= 1'h1;
		cyc(5200);
		chk("irq", irq, 1'h1);
		rd(OFS_STATE, 32'h0000_0001);
		ovs_start_low <= 1'h0;
		for (i = 0; i < 5; i++) begin
			{cs_high, comp_high, fb_high, ocp_trip, otp_hot} <= 5'h01 << i;
			cyc(10);
			rd(OFS_STATE, 32'h0000_0001);
		end
		{cs_high, comp_high, fb_high, ocp_trip, otp_hot} <= 5'h00;
		cyc(10);
		rd(OFS_STATE, 32'h0000_0002);
		// The topology bit is still set but masked off, so a low line here also proves the mask.
		wr(OFS_STATUS, 32'h0000_0001);
		cyc(2);
		chk("irq", irq, 1'h0);
		pulse_req <= 1'h1;
		for (i = 0; i < 2; i++) begin
			peak_at <= i ? 10'h064 : 10'h00A;
			lo = i ? 100 : 60;
			repeat (900) if (!gate_out) cyc(1);
			n = 0;
			while (gate_out && n < 900) begin
				cyc(1);
				n++;
			end
			chk("on_time", n >= lo && n <= lo + 8, 1'h1);
		end
		// The gate is low here, so inhibit cannot cut a pulse short.
		wr(OFS_CTRL, 32'h0000_0001);
		rd(OFS_CTRL, 32'h0000_0001);
		for (i = 0; i < 2; i++) begin
			n = 0;
			repeat (1700) begin
				cyc(1);
				n += gate_out;
			end
			chk("skip", n, 0);
			pulse_req <= 1'h0;
			wr(OFS_CTRL, 32'h0000_0000);
		end
		ovs_over <= 1'h1;
		cyc(8);
		chk("ovp", {comp_discharge, gate_out, soft_start_en}, 3'h4);
		ovs_over <= 1'h0;
		cyc(10);
		chk("restart", soft_start_en, 1'h1);
		otp_hot <= 1'h1;
		cyc(8);
		rd(OFS_STATE, 32'h0000_0004);
		otp_hot <= 1'h0;
		cyc(10);
		rd(OFS_STATE, 32'h0000_0002);
		ovs_short <= 1'h1;
		cyc(8);
		ovs_short <= 1'h0;
		cyc(10);
		rd(OFS_STATE, 32'h0000_0005);
		// Start the low stretch from a high phase so that its length is known.
		while (!dim_in) cyc(1);
		dim_on <= 1'h0;
		cyc(STBY - 20);
		chk("standby", standby_out, 1'h0);
		cyc(40);
		chk("standby", standby_out, 1'h1);
		dim_on <= 1'h1;
		cyc(5200);
		rd(OFS_STATE, 32'h0000_0002);
		comp_high <= 1'h1;
		cyc(30);
		rd(OFS_STATE, 32'h0000_0002);
		cyc(20);
		rd(OFS_STATE, 32'h0000_0005);
		comp_high <= 1'h0;
		supply_ok <= 1'h0;
		cyc(6);
		chk("uvlo", {standby_out, gate_out, soft_start_en}, 3'h4);
		supply_ok <= 1'h1;
		cyc(5200);
		rd(OFS_STATE, 32'h0000_0002);
		cs_high <= 1'h1;
		cyc(15 * 833);
		rd(OFS_STATE, 32'h0000_0002);
		cyc(3 * 833);
		rd(OFS_STATE, 32'h0000_0005);
		complete_run;
	end
endmodule : blfs_top_tb
bind blfs_top blfs_chk #(.STBY_CYC(STBY_CYC)) u_chk (.*);
